// File: rtl/lscss_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LSCSS_DEFS_SVH
`define LSCSS_DEFS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define LSCSS_OFF_FREQ      12'h000
`define LSCSS_OFF_SLOPE     12'h004
`define LSCSS_OFF_CTRL      12'h008
`define LSCSS_OFF_STATUS    12'h00c
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LSCSS_FREQ_W        6
`define LSCSS_FREQ_RST      6'h04
`define LSCSS_FREQ_MAXCODE  6'h1a
`define LSCSS_SLP_LO_LSB    0
`define LSCSS_SLP_HI_LSB    4
`define LSCSS_SLP_RST       2'h0
`define LSCSS_CTRL_EN_BIT   0
`define LSCSS_DIV_W         8
`define LSCSS_DIV_SAFE      8'hb4
`define LSCSS_MAIN_CLK_HZ   8000000
`endif

// File: rtl/lscss_pkg.sv
// Types for the LED switching clock and slope selector
package lscss_pkg;
   typedef logic [1:0] lscss_slope_code_t;
   typedef logic [7:0] lscss_slope_mv_per_us_t;
endpackage

// File: rtl/lscss_divider.sv
// Programmable divider producing the LED switching clock enable and square wave
`timescale 1ns/1ps
`include "lscss_defs.svh"
module lscss_divider
   import lscss_pkg::*;
#(
   parameter int DIV_W = `LSCSS_DIV_W
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             tick_i,
   input  wire logic             run_i,
   input  wire logic [DIV_W-1:0] divisor_i,
   output logic                  period_o,
   output logic                  sw_clk_o
);
   logic [DIV_W-1:0] cnt;
   logic [DIV_W-1:0] next_cnt;
   logic             next_sw_clk;
   logic             next_period;

   // ----------------------------------------
   // Counting on the main clock tick
   // ----------------------------------------
   always_comb begin
      next_cnt    = cnt;
      next_sw_clk = sw_clk_o;
      next_period = 1'b0;
      if (!run_i) begin
         next_cnt    = '0;
         next_sw_clk = 1'b0;
      end else if (tick_i) begin
         if (cnt >= divisor_i - DIV_W'(1)) begin
            next_cnt    = '0;
            next_sw_clk = 1'b1;
            next_period = 1'b1;
         end else begin
            next_cnt = cnt + DIV_W'(1);
            if (cnt + DIV_W'(1) == (divisor_i >> 1)) begin
               next_sw_clk = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt      <= '0;
         sw_clk_o <= 1'b0;
         period_o <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         sw_clk_o <= next_sw_clk;
         period_o <= next_period;
      end
   end
endmodule

// File: rtl/lscss_top.sv
// LED switching clock and slope compensation selector with APB registers
//
// Notes on behaviour
// - All clocks come from one 8 MHz main clock tick.
// - Switching frequency set by 6-bit software code in its own register.
// - Code picks divisor from fixed table, 8 up to 180.
// - Reset code is 4, divide by 16, giving 500 kHz.
// - Low-duty slope below 50 percent, high-duty slope above.
// - Low slopes 0.1 to 0.4, high slopes 0.3 to 0.9 V per us.
// - Both slope fields reset to zero: 0.1 and 0.3 V per us.
// - Switching and slope output only while driver enable bit is set.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "lscss_defs.svh"
module lscss_top
   import lscss_pkg::*;
#(
   parameter int CORE_HZ = 200000000
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        high_duty_i,
   output logic             led_switch_clock_o,
   output logic             period_start_o,
   output logic [7:0]       slope_mv_per_us_o,
   output logic             led_driver_on_o
);
   localparam int TICK_DIV = CORE_HZ / `LSCSS_MAIN_CLK_HZ;
   localparam int TICK_W   = $clog2(TICK_DIV + 1);

   // ----------------------------------------
   // Lookup functions
   // ----------------------------------------
   function automatic logic [7:0] divisor_of(input logic [5:0] code);
      logic [7:0] d;
      d = `LSCSS_DIV_SAFE;
      case (code)
         6'h00: d = 8'h08;
         6'h01: d = 8'h0a;
         6'h02: d = 8'h0c;
         6'h03: d = 8'h0e;
         6'h04: d = 8'h10;
         6'h05: d = 8'h12;
         6'h06: d = 8'h14;
         6'h07: d = 8'h16;
         6'h08: d = 8'h18;
         6'h09: d = 8'h1a;
         6'h0a: d = 8'h1c;
         6'h0b: d = 8'h20;
         6'h0c: d = 8'h22;
         6'h0d: d = 8'h26;
         6'h0e: d = 8'h2a;
         6'h0f: d = 8'h2e;
         6'h10: d = 8'h34;
         6'h11: d = 8'h38;
         6'h12: d = 8'h40;
         6'h13: d = 8'h46;
         6'h14: d = 8'h4c;
         6'h15: d = 8'h54;
         6'h16: d = 8'h66;
         6'h17: d = 8'h70;
         6'h18: d = 8'h7c;
         6'h19: d = 8'h96;
         6'h1a: d = 8'hb4;
         default: d = `LSCSS_DIV_SAFE;
      endcase
      return d;
   endfunction

   // Slope in units of 0.1 V/us
   function automatic lscss_slope_mv_per_us_t slope_of(input logic hi,
                                                       input lscss_slope_code_t c);
      lscss_slope_mv_per_us_t s;
      s = 8'h00;
      if (!hi) begin
         case (c)
            2'h0:    s = 8'h01;
            2'h1:    s = 8'h02;
            2'h2:    s = 8'h03;
            default: s = 8'h04;
         endcase
      end else begin
         case (c)
            2'h0:    s = 8'h03;
            2'h1:    s = 8'h04;
            2'h2:    s = 8'h06;
            default: s = 8'h09;
         endcase
      end
      return s;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [5:0]             freq_code;
   lscss_slope_code_t      slope_lo;
   lscss_slope_code_t      slope_hi;
   logic                   drv_en;
   logic [5:0]             next_freq_code;
   lscss_slope_code_t      next_slope_lo;
   lscss_slope_code_t      next_slope_hi;
   logic                   next_drv_en;
   logic [31:0]            next_prdata;
   logic                   next_pslverr;
   logic                   access;
   logic                   hit;
   logic                   setup;
   logic [15:0]            period_gap;
   logic [15:0]            next_period_gap;
   logic [TICK_W-1:0]      tick_cnt;
   logic [TICK_W-1:0]      next_tick_cnt;
   logic                   tick;
   logic                   period_start;
   logic                   sw_clk;
   lscss_slope_mv_per_us_t next_slope_out;

   assign access   = psel_i && penable_i;
   assign setup    = psel_i && !penable_i;
   assign pready_o = 1'b1;

   always_comb begin
      next_freq_code = freq_code;
      next_slope_lo  = slope_lo;
      next_slope_hi  = slope_hi;
      next_drv_en    = drv_en;
      next_prdata    = prdata_o;
      next_pslverr   = 1'b0;
      hit            = 1'b1;
      case (paddr_i)
         `LSCSS_OFF_FREQ, `LSCSS_OFF_SLOPE, `LSCSS_OFF_CTRL, `LSCSS_OFF_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      if (setup) begin
         next_pslverr = !hit;
         next_prdata  = 32'h0;
         if (!pwrite_i) begin
            case (paddr_i)
               `LSCSS_OFF_FREQ:  next_prdata = {26'h0, freq_code};
               `LSCSS_OFF_SLOPE: next_prdata = {26'h0, slope_hi, 2'h0, slope_lo};
               `LSCSS_OFF_CTRL:  next_prdata = {31'h0, drv_en};
               `LSCSS_OFF_STATUS: next_prdata = {divisor_of(freq_code), 22'h0,
                                                 high_duty_i, sw_clk};
               default: next_prdata = 32'h0;
            endcase
         end
      end
      if (access && pwrite_i && pstrb_i[0]) begin
         case (paddr_i)
            `LSCSS_OFF_FREQ: next_freq_code = pwdata_i[5:0];
            `LSCSS_OFF_SLOPE: begin
               next_slope_lo = pwdata_i[`LSCSS_SLP_LO_LSB +: 2];
               next_slope_hi = pwdata_i[`LSCSS_SLP_HI_LSB +: 2];
            end
            `LSCSS_OFF_CTRL: next_drv_en = pwdata_i[`LSCSS_CTRL_EN_BIT];
            default: next_drv_en = drv_en;
         endcase
      end
   end

   // Main 8 MHz tick from the core clock
   always_comb begin
      next_tick_cnt = tick_cnt + TICK_W'(1);
      tick          = 1'b0;
      if (tick_cnt == TICK_W'(TICK_DIV - 1)) begin
         next_tick_cnt = '0;
         tick          = 1'b1;
      end
      next_slope_out = drv_en ? slope_of(high_duty_i, high_duty_i ? slope_hi : slope_lo)
                              : 8'h00;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         freq_code         <= `LSCSS_FREQ_RST;
         slope_lo          <= `LSCSS_SLP_RST;
         slope_hi          <= `LSCSS_SLP_RST;
         drv_en            <= 1'b0;
         prdata_o          <= 32'h0;
         pslverr_o         <= 1'b0;
         tick_cnt          <= '0;
         slope_mv_per_us_o <= 8'h00;
      end else begin
         freq_code         <= next_freq_code;
         slope_lo          <= next_slope_lo;
         slope_hi          <= next_slope_hi;
         drv_en            <= next_drv_en;
         prdata_o          <= next_prdata;
         pslverr_o         <= next_pslverr;
         tick_cnt          <= next_tick_cnt;
         slope_mv_per_us_o <= next_slope_out;
      end
   end

   // ----------------------------------------
   // Switching clock divider
   // ----------------------------------------
   lscss_divider #(
      .DIV_W(`LSCSS_DIV_W)
   ) u_div (
      .core_clk_i(core_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (tick),
      .run_i     (drv_en),
      .divisor_i (divisor_of(freq_code)),
      .period_o  (period_start),
      .sw_clk_o  (sw_clk)
   );

   assign led_switch_clock_o = sw_clk;
   assign period_start_o     = period_start;
   assign led_driver_on_o    = drv_en;

   // Cycles since the last period start, for the period length check
   localparam logic [15:0] PERIOD_MAX = 16'((`LSCSS_DIV_SAFE + 1) * TICK_DIV);
   always_comb begin
      next_period_gap = (period_start || !drv_en) ? 16'h0000 : period_gap + 16'h0001;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         period_gap <= 16'h0000;
      end else begin
         period_gap <= next_period_gap;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_reset_code;
      @(posedge core_clk_i) $rose(rst_n_i) |-> freq_code == 6'h04 && slope_lo == 2'h0;
   endproperty
   a_reset_code: assert property (p_reset_code) else $error("Bad reset code");

   property p_reset_slope;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(drv_en) && slope_lo == 2'h0 && !high_duty_i |=> slope_mv_per_us_o == 8'h01;
   endproperty
   a_reset_slope: assert property (p_reset_slope) else $error("Bad low slope");

   property p_hi_slope;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         drv_en && high_duty_i && slope_hi == 2'h3 |=> slope_mv_per_us_o == 8'h09;
   endproperty
   a_hi_slope: assert property (p_hi_slope) else $error("Bad high slope");

   property p_off_quiet;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !drv_en ##1 !drv_en |-> !sw_clk && slope_mv_per_us_o == 8'h00;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("Switching while off");

   property p_reserved;
      @(posedge core_clk_i) freq_code > 6'h1a |-> divisor_of(freq_code) == 8'hb4;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved code divisor");

   property p_tick;
      @(posedge core_clk_i) disable iff (!rst_n_i) tick |=> !tick [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("Tick spacing short");

   property p_write_freq;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         access && pwrite_i && pstrb_i[0] && paddr_i == `LSCSS_OFF_FREQ
         |=> freq_code == $past(pwdata_i[5:0]);
   endproperty
   a_write_freq: assert property (p_write_freq) else $error("Code not stored");

   property p_period;
      @(posedge core_clk_i) disable iff (!rst_n_i) drv_en |-> period_gap <= PERIOD_MAX;
   endproperty
   a_period: assert property (p_period) else $error("Period too long");

   property p_tick_gap;
      @(posedge core_clk_i) disable iff (!rst_n_i) tick |=> !tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Tick too close");

   property p_sel;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         drv_en && !high_duty_i && slope_lo == 2'h2 |=> slope_mv_per_us_o == 8'h03;
   endproperty
   a_sel: assert property (p_sel) else $error("Low slope select");

   c_period: cover property (@(posedge core_clk_i) period_start);
   c_hi: cover property (@(posedge core_clk_i) drv_en && high_duty_i);
   c_err: cover property (@(posedge core_clk_i) pslverr_o);
endmodule

// File: verif/lscss_power_stage.sv
// Behavioural power stage that sets the duty level and counts switching periods
`timescale 1ns/1ps
module lscss_power_stage (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        duty_above_half_i,
   input  wire logic        period_start_i,
   input  wire logic        driver_on_i,
   output logic             high_duty_o,
   output logic [15:0]      periods_o
);
   // ----------------------------------------
   // Duty level and period counter
   // ----------------------------------------
   logic        next_high_duty;
   logic [15:0] next_periods;
   always_comb begin
      next_high_duty = duty_above_half_i;
      next_periods   = periods_o;
      if (period_start_i && driver_on_i) begin
         next_periods = periods_o + 16'h0001;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         high_duty_o <= 1'b0;
         periods_o   <= 16'h0000;
      end else begin
         high_duty_o <= next_high_duty;
         periods_o   <= next_periods;
      end
   end
endmodule

// File: verif/lscss_top_test.sv
// Register and switching clock testbench for the LED clock and slope selector
`timescale 1ns/1ps
`include "lscss_defs.svh"
module lscss_top_test;
   import lscss_pkg::*;
   // ----------------------------------------
   // Signals and tables
   // ----------------------------------------
   localparam int TICK = 200000000 / `LSCSS_MAIN_CLK_HZ;
   localparam logic [7:0] DIV_TAB [27] = '{8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14,
      8'h16, 8'h18, 8'h1a, 8'h1c, 8'h20, 8'h22, 8'h26, 8'h2a, 8'h2e, 8'h34, 8'h38, 8'h40,
      8'h46, 8'h4c, 8'h54, 8'h66, 8'h70, 8'h7c, 8'h96, 8'hb4};
   localparam logic [7:0] LO_TAB [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
   localparam logic [7:0] HI_TAB [4] = '{8'h03, 8'h04, 8'h06, 8'h09};
   logic        core_clk_i;
   logic        rst_n_i;
   logic        psel_i;
   logic        penable_i;
   logic        pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [3:0]  pstrb_i;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        high_duty_i;
   logic        led_switch_clock_o;
   logic        period_start_o;
   logic [7:0]  slope_mv_per_us_o;
   logic        led_driver_on_o;
   logic        duty_sel;
   logic [15:0] periods;
   int          miscompares;
   int          checks_done;
   lscss_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .high_duty_i(high_duty_i), .led_switch_clock_o(led_switch_clock_o),
      .period_start_o(period_start_o), .slope_mv_per_us_o(slope_mv_per_us_o),
      .led_driver_on_o(led_driver_on_o));
   lscss_power_stage stage (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .duty_above_half_i(duty_sel), .period_start_i(period_start_o),
      .driver_on_i(led_driver_on_o), .high_duty_o(high_duty_i), .periods_o(periods));
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
      int n;
      @(posedge core_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      pstrb_i   <= s;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk_i);
         if (pready_o === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         stop_test();
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, s, q, e);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                         input logic [31:0] m);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, 4'h0, q, e);
      check(what, exp, q & m);
      check("slverr", 32'h0, {31'h0, e});
   endtask
   task automatic wait_pulse(output int n);
      for (n = 0; n < 6000; n++) begin
         @(posedge core_clk_i);
         #1;
         if (period_start_o === 1'b1) break;
      end
      if (n == 6000) begin
         miscompares++;
         stop_test();
      end
      n = n + 1;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int          c;
      int          code;
      int          n;
      logic [15:0] p0;
      logic [31:0] q;
      logic        e;
      miscompares = 0;
      checks_done = 0;
      rst_n_i   <= 1'b0;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      pwrite_i  <= 1'b0;
      paddr_i   <= 12'h000;
      pwdata_i  <= 32'h0;
      pstrb_i   <= 4'h0;
      duty_sel  <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd_chk("freq", `LSCSS_OFF_FREQ, 32'h4, 32'h3f);
      rd_chk("slope", `LSCSS_OFF_SLOPE, 32'h0, 32'h33);
      rd_chk("ctrl", `LSCSS_OFF_CTRL, 32'h0, 32'h1);
      rd_chk("div", `LSCSS_OFF_STATUS, 32'h10000000, 32'hff000000);
      check("slope_off", 32'h0, {24'h0, slope_mv_per_us_o});
      for (c = 0; c < 29; c++) begin
         code = (c < 27) ? c : ((c == 27) ? 27 : 63);
         wr(`LSCSS_OFF_FREQ, code, 4'hf);
         rd_chk("freq", `LSCSS_OFF_FREQ, code, 32'h3f);
         rd_chk("div", `LSCSS_OFF_STATUS, {DIV_TAB[(code < 27) ? code : 26], 24'h0},
                32'hff000000);
      end
      wr(`LSCSS_OFF_FREQ, 32'h5, 4'h0);
      rd_chk("freq_nostrb", `LSCSS_OFF_FREQ, 32'h3f, 32'h3f);
      apb(1'b0, 12'h010, 32'h0, 4'h0, q, e);
      check("slverr_unmapped", 32'h1, {31'h0, e});
      wr(`LSCSS_OFF_FREQ, 32'h0, 4'hf);
      wr(`LSCSS_OFF_CTRL, 32'h1, 4'hf);
      @(posedge core_clk_i);
      check("driver_on", 32'h1, {31'h0, led_driver_on_o});
      wait_pulse(n);
      wait_pulse(n);
      check("period0", DIV_TAB[0] * TICK, n);
      p0 = periods;
      wr(`LSCSS_OFF_FREQ, 32'h4, 4'hf);
      wait_pulse(n);
      wait_pulse(n);
      check("period4", DIV_TAB[4] * TICK, n);
      check("sw_clk_hi", 32'h1, {31'h0, led_switch_clock_o});
      repeat (250) @(posedge core_clk_i);
      #1;
      check("sw_clk_lo", 32'h0, {31'h0, led_switch_clock_o});
      check("periods_run", 32'h1, {31'h0, periods > p0});
      for (c = 0; c < 4; c++) begin
         wr(`LSCSS_OFF_SLOPE, (c << `LSCSS_SLP_HI_LSB) | c, 4'hf);
         @(posedge core_clk_i);
         duty_sel <= 1'b0;
         repeat (4) @(posedge core_clk_i);
         #1;
         check("slope_lo", LO_TAB[c], slope_mv_per_us_o);
         @(posedge core_clk_i);
         duty_sel <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         #1;
         check("slope_hi", HI_TAB[c], slope_mv_per_us_o);
      end
      wr(`LSCSS_OFF_SLOPE, 32'h0, 4'hf);
      repeat (3) @(posedge core_clk_i);
      #1;
      check("slope_zero_hi", HI_TAB[0], slope_mv_per_us_o);
      wr(`LSCSS_OFF_CTRL, 32'h0, 4'hf);
      repeat (3) @(posedge core_clk_i);
      p0 = periods;
      repeat (500) @(posedge core_clk_i);
      #1;
      check("periods_stop", p0, periods);
      check("slope_stop", 32'h0, {24'h0, slope_mv_per_us_o});
      stop_test();
   end
endmodule
